// File: src/plp_pkg.sv
package plp_pkg;
  // Management register addresses
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_STAT = 5'h01;
  localparam logic [4:0] REG_ADV = 5'h04;
  localparam logic [4:0] REG_PARTNER = 5'h05;
  localparam logic [4:0] REG_EXP = 5'h06;
  localparam logic [4:0] REG_SPECIAL = 5'h1B;
  localparam logic [4:0] REG_INT_SRC = 5'h1D;
  localparam logic [4:0] REG_INT_MASK = 5'h1E;
  // Basic control fields
  localparam int CTRL_SPEED = 13;
  localparam int CTRL_AN_EN = 12;
  localparam int CTRL_PWR_DWN = 11;
  localparam int CTRL_RESTART = 9;
  localparam int CTRL_DUPLEX = 8;
  // Basic status fields
  localparam int STAT_AN_DONE = 5;
  localparam int STAT_LINK = 2;
  // Expansion fields
  localparam int EXP_PARTNER_ABLE = 0;
  localparam int EXP_PD_FAULT = 4;
  // Special indication fields
  localparam int SPC_OVERRIDE = 15;
  localparam int SPC_AUTO_EN = 14;
  localparam int SPC_FIXED = 13;
  // Interrupt source and mask bits
  localparam int INT_ENERGY = 7;
  localparam int INT_AN_DONE = 6;
  localparam int INT_REMOTE = 5;
  localparam int INT_LINK_DOWN = 4;
  localparam int INT_LP_ACK = 3;
  localparam int INT_PD_FAULT = 2;
  localparam int INT_PAGE = 1;
  // Partner ability fields written after parallel detection
  localparam int PA_100_HALF = 7;
  localparam int PA_10_HALF = 5;
  localparam logic [15:0] PA_SELECTOR = 16'h0001;
  // Reset values
  localparam logic [15:0] CTRL_RST = 16'h3100;
  localparam logic [15:0] STAT_RST = 16'h7808;
  localparam logic [15:0] ADV_RST = 16'h01E1;
  localparam logic [15:0] SPC_RST = 16'h0000;
  localparam logic [15:0] MASK_RST = 16'h0000;
  localparam logic [15:0] UNSUP_READ = 16'hFFFF;
  // Timing
  localparam int CLK_HZ = 20000000;
  localparam int BREAK_MS = 1200;
  localparam int BREAK_CYCLES = BREAK_MS * (CLK_HZ / 1000);
  localparam logic [2:0] RXCLK_HALF = 3'h3;
  // Management frame lengths
  localparam logic [5:0] PRE_LEN = 6'h20;
  localparam logic [4:0] HDR_LEN = 5'h0D;
  localparam logic [4:0] DATA_LEN = 5'h12;

  typedef enum logic [3:0] {
    ST_DOWN = 4'b0001,
    ST_BREAK = 4'b0010,
    ST_NEG = 4'b0100,
    ST_LINK = 4'b1000
  } plp_state_type;

  typedef enum logic [3:0] {
    MS_PRE = 4'b0001,
    MS_HDR = 4'b0010,
    MS_RD = 4'b0100,
    MS_WR = 4'b1000
  } plp_mstate_type;

  typedef struct packed {
    logic flp_seen;
    logic mlt3_seen;
    logic nlp_seen;
    logic signal_ok;
    logic an_done;
    logic hcd_speed100;
    logic hcd_full;
    logic pd_fault;
    logic page_rcvd;
    logic lp_ack;
    logic remote_fault;
    logic mdix_detect;
    logic rx_active;
  } plp_line_type;

  typedef struct packed {
    logic link_up;
    logic speed100;
    logic full_duplex;
    logic mdix;
  } plp_mode_type;
endpackage

// File: src/plp_ctrl.sv
// What this block does
// - No pulses: speed from symbols, half duplex
// - Parallel link clears partner-capable flag
// - Fault during parallel detection sets flag
// - Store partner ability; parallel updates speed
// - Restart on control bit or signal loss
// - Restart write stops traffic, waits break
// - Negotiation off forces control speed, duplex
// - Negotiation on ignores forced bits
// - Half duplex: carrier both ways, collisions
// - Full duplex: carrier receive only, no collision
// - Override set: register bits choose crossover
// - Receive clock recovered or from reference
// - Unsupported register reads return all ones
// - Source read returns flags, clears interrupt
// - Masked events merge onto one interrupt
// - Interrupt bit positions seven down to one
// - Power-down never resets the registers
// - Power-down bit idles link and transmit; receive clock keeps running
// - External interface selection forces power-down
// - Advertisement write alone never restarts
`timescale 1ns/1ps

module plp_fifo #(
  parameter int WIDTH = 4,
  parameter int DEPTH = 8
) (
  input wire logic clk_in, // System clock
  input wire logic rst_n_in, // Async reset
  input wire logic [WIDTH-1:0] in_data_in, // Write data
  input wire logic in_valid_in, // Write request
  output logic in_ready_out, // Room left
  output logic [WIDTH-1:0] out_data_out, // Head word
  output logic out_valid_out, // Head word valid
  input wire logic out_ready_in // Head taken
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] cnt_q, cnt_d;
  logic ready_q, valid_q;
  logic push, pop;

  always_comb
  begin
    push = in_valid_in & ready_q;
    pop = out_ready_in & valid_q;
    wr_d = push ? wr_q + 1'b1 : wr_q;
    rd_d = pop ? rd_q + 1'b1 : rd_q;
    cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  // Flags are registered so the ports come straight from flops
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      ready_q <= 1'b1;
      valid_q <= 1'b0;
    end
    else
    begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
      ready_q <= cnt_d != (AW+1)'(DEPTH);
      valid_q <= cnt_d != '0;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (push)
      mem_q[wr_q] <= in_data_in;
  end

  assign in_ready_out = ready_q;
  assign out_valid_out = valid_q;
  assign out_data_out = mem_q[rd_q];
endmodule

module plp_ctrl import plp_pkg::*; #(
  parameter logic [4:0] PHY_ADDR = 5'h01, // Arbitrary default address
  parameter int BREAK_CNT = BREAK_CYCLES
) (
  input wire logic clk_in, // 20 MHz reference clock
  input wire logic rst_n_in, // Async reset, active low
  input wire logic mdc_in, // Management clock pin
  input wire logic mdio_in, // Management data pin level
  output logic mdio_out, // Management data driven value
  output logic mdio_oe_out, // High while driving mdio
  input wire logic auto_mdix_strap_in, // Auto crossover strap
  input wire logic manual_mdix_strap_in, // Manual crossover strap
  input wire logic line_energy_present_in, // Energy on the line
  input wire logic rx_rclk_in, // Recovered receive clock
  input wire logic ext_mii_sel_in, // External MII chosen for port
  input wire plp_line_type line_in, // Line-side status
  input wire logic [15:0] partner_word_in, // Received link code word
  input wire logic [3:0] txd_in, // MAC transmit nibble
  input wire logic txen_in, // MAC transmit enable
  input wire logic [3:0] rx_nibble_in, // Line receive nibble
  input wire logic rx_valid_in, // Receive nibble valid
  output logic rx_ready_out, // Receive buffer has room
  input wire logic mac_ready_in, // MAC takes receive nibble
  output logic [3:0] rxd_out, // Receive nibble to MAC
  output logic rxdv_out, // Receive nibble valid
  output logic rxclk_out, // Receive clock to MAC
  output logic [3:0] line_txd_out, // Transmit nibble to line
  output logic line_txen_out, // Transmit enable to line
  output logic crs_out, // Carrier sense
  output logic col_out, // Collision
  output plp_mode_type mode_out, // Resolved link mode
  output logic an_start_out, // Start negotiation pulse
  output logic power_down_out, // Analog power-down
  output logic phy_irq_out // Port event to system
);
  localparam int S_MDC = 5;
  localparam int S_MDIO = 4;
  localparam int S_ENERGY = 3;
  localparam int S_AUTO = 2;
  localparam int S_MANUAL = 1;
  localparam int S_RCLK = 0;

  // Pins pass two flops; only the second stage feeds logic
  logic [5:0] sync1_q, sync2_q;
  logic mdc_prev_q, energy_prev_q;
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
      mdc_prev_q <= 1'b0;
      energy_prev_q <= 1'b0;
    end
    else
    begin
      sync1_q <= {mdc_in, mdio_in, line_energy_present_in,
                  auto_mdix_strap_in, manual_mdix_strap_in, rx_rclk_in};
      sync2_q <= sync1_q;
      mdc_prev_q <= sync2_q[S_MDC];
      energy_prev_q <= sync2_q[S_ENERGY];
    end
  end

  logic mdc_rise, mdio_s;
  assign mdc_rise = sync2_q[S_MDC] & ~mdc_prev_q;
  assign mdio_s = sync2_q[S_MDIO];

  // Register state
  logic [15:0] ctrl_q, ctrl_d, adv_q, adv_d, spc_q, spc_d;
  logic [15:0] mask_q, mask_d, partner_q, partner_d, exp_q, exp_d;
  logic [15:0] src_q, src_d;

  // Management serial slave
  plp_mstate_type mst_q, mst_d;
  logic [5:0] mcnt_q, mcnt_d;
  logic [15:0] shift_q, shift_d, rdata_q, rdata_d;
  logic [4:0] regad_q, regad_d;
  logic mdo_q, mdo_d, mdoe_q, mdoe_d;
  logic wr_stb, src_clr;
  logic [15:0] rd_mux;

  always_comb
  begin
    if (regad_d == REG_CTRL)
      rd_mux = ctrl_q;
    else if (regad_d == REG_STAT)
      rd_mux = STAT_RST | 16'(mode_out.link_up) << STAT_LINK
             | 16'(mode_out.link_up & ctrl_q[CTRL_AN_EN]) << STAT_AN_DONE;
    else if (regad_d == REG_ADV)
      rd_mux = adv_q;
    else if (regad_d == REG_PARTNER)
      rd_mux = partner_q;
    else if (regad_d == REG_EXP)
      rd_mux = exp_q;
    else if (regad_d == REG_SPECIAL)
      rd_mux = spc_q;
    else if (regad_d == REG_INT_SRC)
      rd_mux = src_q;
    else if (regad_d == REG_INT_MASK)
      rd_mux = mask_q;
    else
      rd_mux = UNSUP_READ;
  end

  always_comb
  begin
    mst_d = mst_q;
    mcnt_d = mcnt_q;
    shift_d = shift_q;
    rdata_d = rdata_q;
    regad_d = regad_q;
    mdo_d = mdo_q;
    mdoe_d = mdoe_q;
    wr_stb = 1'b0;
    src_clr = 1'b0;
    if (mdc_rise)
    begin
      shift_d = {shift_q[14:0], mdio_s};
      mcnt_d = mcnt_q + 6'h01;
      case (mst_q)
        MS_PRE:
        begin
          if (!mdio_s && mcnt_q >= PRE_LEN)
          begin
            mst_d = MS_HDR;
            mcnt_d = '0;
          end
          else if (!mdio_s)
            mcnt_d = '0;
          else if (mcnt_q >= PRE_LEN)
            mcnt_d = mcnt_q;
        end
        MS_HDR:
        begin
          if (mcnt_q == 6'(HDR_LEN - 5'h01))
          begin
            regad_d = shift_d[4:0];
            mcnt_d = '0;
            mst_d = MS_PRE;
            if (shift_d[12] && shift_d[9:5] == PHY_ADDR)
            begin
              if (shift_d[11:10] == 2'b10)
              begin
                mst_d = MS_RD;
                rdata_d = rd_mux;
                src_clr = regad_d == REG_INT_SRC;
              end
              else if (shift_d[11:10] == 2'b01)
                mst_d = MS_WR;
            end
          end
        end
        MS_RD:
        begin
          if (mcnt_q == '0)
          begin
            mdoe_d = 1'b1;
            mdo_d = 1'b0;
          end
          else if (mcnt_q < 6'(DATA_LEN - 5'h01))
          begin
            mdo_d = rdata_q[15];
            rdata_d = {rdata_q[14:0], 1'b0};
          end
          else
          begin
            mdoe_d = 1'b0;
            mdo_d = 1'b0;
            mcnt_d = '0;
            mst_d = MS_PRE;
          end
        end
        MS_WR:
        begin
          if (mcnt_q == 6'(DATA_LEN - 5'h01))
          begin
            wr_stb = 1'b1;
            mcnt_d = '0;
            mst_d = MS_PRE;
          end
        end
        default:
        begin
          mst_d = MS_PRE;
          mcnt_d = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      mst_q <= MS_PRE;
      mcnt_q <= '0;
      shift_q <= '0;
      rdata_q <= '0;
      regad_q <= '0;
      mdo_q <= 1'b0;
      mdoe_q <= 1'b0;
    end
    else
    begin
      mst_q <= mst_d;
      mcnt_q <= mcnt_d;
      shift_q <= shift_d;
      rdata_q <= rdata_d;
      regad_q <= regad_d;
      mdo_q <= mdo_d;
      mdoe_q <= mdoe_d;
    end
  end

  // Link control and registers
  plp_state_type st_q, st_d;
  logic [31:0] brk_q, brk_d;
  plp_mode_type mode_q, mode_d;
  logic start_q, start_d, irq_q, irq_d, pwr_q, pwr_d;
  logic pwr_req, an_en, restart_wr, xo_auto, xo_fixed;
  logic [15:0] ev;

  always_comb
  begin
    st_d = st_q;
    brk_d = brk_q;
    mode_d = mode_q;
    start_d = 1'b0;
    ctrl_d = ctrl_q;
    adv_d = adv_q;
    spc_d = spc_q;
    mask_d = mask_q;
    partner_d = partner_q;
    exp_d = exp_q;
    ev = '0;
    // Writes change storage only; power-down never reloads them
    // The last data bit lands on the strobe edge, so take the next shift
    restart_wr = wr_stb && regad_q == REG_CTRL && shift_d[CTRL_RESTART];
    if (wr_stb && regad_q == REG_CTRL)
      ctrl_d = shift_d;
    if (wr_stb && regad_q == REG_ADV)
      adv_d = shift_d;
    if (wr_stb && regad_q == REG_SPECIAL)
      spc_d = shift_d;
    if (wr_stb && regad_q == REG_INT_MASK)
      mask_d = shift_d;
    pwr_req = ctrl_d[CTRL_PWR_DWN] | ext_mii_sel_in;
    an_en = ctrl_q[CTRL_AN_EN];
    if (line_in.page_rcvd)
    begin
      partner_d = partner_word_in;
      ev[INT_PAGE] = 1'b1;
    end
    ev[INT_ENERGY] = sync2_q[S_ENERGY] & ~energy_prev_q;
    ev[INT_REMOTE] = line_in.remote_fault;
    ev[INT_LP_ACK] = line_in.lp_ack;
    case (st_q)
      ST_DOWN:
      begin
        mode_d.link_up = 1'b0;
        // Leaving power-down restarts the link logic only
        if (!pwr_req)
        begin
          st_d = ST_NEG;
          start_d = an_en;
        end
      end
      ST_BREAK:
      begin
        mode_d.link_up = 1'b0;
        brk_d = brk_q - 32'h1;
        if (brk_q == '0)
        begin
          st_d = ST_NEG;
          start_d = 1'b1;
          ctrl_d[CTRL_RESTART] = 1'b0;
        end
      end
      ST_NEG:
      begin
        if (!an_en && line_in.signal_ok)
        begin
          st_d = ST_LINK;
          mode_d.link_up = 1'b1;
          mode_d.speed100 = ctrl_q[CTRL_SPEED];
          mode_d.full_duplex = ctrl_q[CTRL_DUPLEX];
        end
        else if (an_en && line_in.an_done)
        begin
          st_d = ST_LINK;
          mode_d.link_up = 1'b1;
          mode_d.speed100 = line_in.hcd_speed100;
          mode_d.full_duplex = line_in.hcd_full;
          exp_d[EXP_PARTNER_ABLE] = 1'b1;
          ev[INT_AN_DONE] = 1'b1;
        end
        else if (an_en && !line_in.flp_seen && line_in.signal_ok
                 && (line_in.mlt3_seen || line_in.nlp_seen))
        begin
          st_d = ST_LINK;
          mode_d.link_up = 1'b1;
          mode_d.speed100 = line_in.mlt3_seen;
          mode_d.full_duplex = 1'b0;
          exp_d[EXP_PARTNER_ABLE] = 1'b0;
          partner_d = PA_SELECTOR | (line_in.mlt3_seen
                      ? 16'h0001 << PA_100_HALF : 16'h0001 << PA_10_HALF);
        end
        if (an_en && line_in.pd_fault)
        begin
          exp_d[EXP_PD_FAULT] = 1'b1;
          ev[INT_PD_FAULT] = 1'b1;
        end
      end
      ST_LINK:
      begin
        if (!line_in.signal_ok)
        begin
          st_d = ST_NEG;
          mode_d.link_up = 1'b0;
          start_d = an_en;
          ev[INT_LINK_DOWN] = 1'b1;
        end
        else if (!an_en)
        begin
          // Forced bits take effect on a live link too
          mode_d.speed100 = ctrl_q[CTRL_SPEED];
          mode_d.full_duplex = ctrl_q[CTRL_DUPLEX];
        end
      end
      default:
        st_d = ST_DOWN;
    endcase
    if (restart_wr && st_q != ST_DOWN)
    begin
      st_d = ST_BREAK;
      brk_d = 32'(BREAK_CNT - 1);
      start_d = 1'b0;
      mode_d.link_up = 1'b0;
    end
    if (pwr_req)
    begin
      st_d = ST_DOWN;
      start_d = 1'b0;
      mode_d.link_up = 1'b0;
    end
    xo_auto = spc_q[SPC_OVERRIDE] ? spc_q[SPC_AUTO_EN]
                                 : sync2_q[S_AUTO];
    xo_fixed = spc_q[SPC_OVERRIDE] ? spc_q[SPC_FIXED]
                                  : sync2_q[S_MANUAL];
    mode_d.mdix = xo_auto ? line_in.mdix_detect : xo_fixed;
    // Set wins over the read that clears
    src_d = (src_q & ~(src_clr ? 16'hFFFF : 16'h0000)) | ev;
    irq_d = |(src_d & mask_d);
    pwr_d = pwr_req;
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      st_q <= ST_NEG;
      brk_q <= '0;
      mode_q <= '0;
      start_q <= 1'b0;
      irq_q <= 1'b0;
      pwr_q <= 1'b0;
      ctrl_q <= CTRL_RST;
      adv_q <= ADV_RST;
      spc_q <= SPC_RST;
      mask_q <= MASK_RST;
      partner_q <= '0;
      exp_q <= '0;
      src_q <= '0;
    end
    else
    begin
      st_q <= st_d;
      brk_q <= brk_d;
      mode_q <= mode_d;
      start_q <= start_d;
      irq_q <= irq_d;
      pwr_q <= pwr_d;
      ctrl_q <= ctrl_d;
      adv_q <= adv_d;
      spc_q <= spc_d;
      mask_q <= mask_d;
      partner_q <= partner_d;
      exp_q <= exp_d;
      src_q <= src_d;
    end
  end

  // Data path: quiet during break and power-down
  logic active, rx_act, fifo_valid, pop;
  logic [3:0] fifo_data;
  logic [3:0] txd_q, rxd_q;
  logic txen_q, crs_q, col_q, rxdv_q, rxclk_q;
  logic [2:0] div_q;
  assign active = (st_q == ST_NEG) || (st_q == ST_LINK);
  assign rx_act = line_in.rx_active & active;
  assign pop = fifo_valid & (~rxdv_q | mac_ready_in);

  plp_fifo #(.WIDTH(4), .DEPTH(8)) u_rx_fifo (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .in_data_in(rx_nibble_in),
    .in_valid_in(rx_valid_in & active),
    .in_ready_out(rx_ready_out),
    .out_data_out(fifo_data),
    .out_valid_out(fifo_valid),
    .out_ready_in(pop)
  );

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      txd_q <= '0;
      txen_q <= 1'b0;
      crs_q <= 1'b0;
      col_q <= 1'b0;
      rxd_q <= '0;
      rxdv_q <= 1'b0;
      rxclk_q <= 1'b0;
      div_q <= '0;
    end
    else
    begin
      txd_q <= txd_in;
      txen_q <= txen_in & active;
      crs_q <= mode_q.full_duplex ? rx_act
                                  : rx_act | (txen_in & active);
      col_q <= ~mode_q.full_duplex & txen_in & active & rx_act;
      if (pop)
        rxd_q <= fifo_data;
      if (pop)
        rxdv_q <= 1'b1;
      else if (mac_ready_in)
        rxdv_q <= 1'b0;
      // Reference divider only reaches the 10 Mb/s nibble rate
      div_q <= (div_q == RXCLK_HALF) ? 3'h0 : div_q + 3'h1;
      if (rx_act)
        rxclk_q <= sync2_q[S_RCLK];
      else if (div_q == RXCLK_HALF)
        rxclk_q <= ~rxclk_q;
    end
  end

  assign mdio_out = mdo_q;
  assign mdio_oe_out = mdoe_q;
  assign rxd_out = rxd_q;
  assign rxdv_out = rxdv_q;
  assign rxclk_out = rxclk_q;
  assign line_txd_out = txd_q;
  assign line_txen_out = txen_q;
  assign crs_out = crs_q;
  assign col_out = col_q;
  assign mode_out = mode_q;
  assign an_start_out = start_q;
  assign power_down_out = pwr_q;
  assign phy_irq_out = irq_q;

  chk_unsup_read: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    mst_q == MS_HDR && mst_d == MS_RD && regad_d == 5'h1F
    |=> rdata_q == 16'hFFFF) else $error("unsupported read not all ones");
  chk_half_col: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !mode_q.full_duplex && txen_in && rx_act && $stable(mode_q)
    |=> col_q && crs_q) else $error("half duplex collision missed");
  chk_full_nocol: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    mode_q.full_duplex |=> !col_q) else $error("collision in full duplex");
  chk_break_quiet: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    st_q == ST_BREAK && brk_q != '0 |=> !txen_q ##1 !txen_q)
    else $error("traffic in break");
  chk_break_start: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    restart_wr && st_q != ST_DOWN && !pwr_req |=> st_q == ST_BREAK
    && brk_q == 32'(BREAK_CNT - 1)) else $error("break not entered");
  chk_forced_mode: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    st_q == ST_NEG && !an_en && line_in.signal_ok && !pwr_req && !restart_wr
    |=> mode_q.speed100 == $past(ctrl_q[CTRL_SPEED])) else $error("forced");
  chk_parallel_half: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $rose(mode_q.link_up) && !exp_q[EXP_PARTNER_ABLE] && $past(an_en)
    |-> !mode_q.full_duplex) else $error("parallel link not half");
  chk_src_clear: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    src_clr && ev == '0 |=> src_q == '0 ##1 !irq_q || src_q != '0)
    else $error("source read did not clear");
  chk_mask_gate: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    irq_q == |(src_q & mask_q)) else $error("interrupt not masked source");
  chk_pwr_down: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ext_mii_sel_in ##1 ext_mii_sel_in |-> st_q == ST_DOWN && pwr_q)
    else $error("external select not powered down");
endmodule

// File: verif/plp_mac_model.sv
`timescale 1ns/1ps
module plp_mac_model (
  input wire logic clk_in, // Nibble clock
  input wire logic send_in, // Keep transmitting
  input wire logic stall_in, // Hold off receive
  input wire logic [3:0] rxd_in, // Receive nibble
  input wire logic rxdv_in, // Receive valid
  output logic [3:0] txd_out, // Transmit nibble
  output logic txen_out, // Transmit enable
  output logic mac_ready_out, // Receive accepted
  output logic [3:0] got_out, // Last nibble taken
  output int count_out // Nibbles taken
);
  initial
  begin
    txd_out = 4'h0;
    txen_out = 1'b0;
    got_out = 4'h0;
    count_out = 0;
  end
  assign mac_ready_out = !stall_in;
  // Nibble moves every cycle so stale data never looks valid
  always @(posedge clk_in)
  begin
    if (rxdv_in && mac_ready_out)
    begin
      got_out <= rxd_in;
      count_out <= count_out + 1;
    end
    #1;
    txen_out <= send_in;
    txd_out <= txd_out + 4'h1;
  end
endmodule

// File: verif/tb_top.sv
`timescale 1ns/1ps
module tb_top import plp_pkg::*;;
  localparam int BRK = 20;
  typedef struct {logic [4:0] r; logic [15:0] v;} plp_row_type;
  plp_row_type rows[7] = '{'{REG_CTRL, CTRL_RST}, '{REG_STAT, STAT_RST},
    '{REG_ADV, ADV_RST}, '{REG_SPECIAL, SPC_RST},
    '{REG_INT_MASK, MASK_RST}, '{5'h10, UNSUP_READ}, '{5'h1F, UNSUP_READ}};
  logic clk_in = 0, rst_n_in = 0, mdc = 0, drv = 1, mdio_w;
  logic ext_sel = 0, energy = 0, send = 0, stall = 0, rxv = 0;
  logic [3:0] rxn = 0, rxd, txd, got;
  logic mdio_o, mdio_oe, rx_rdy, rxdv, ltxen, crs, col, an_st, pd, irq;
  logic mready, mtxen, rxclk, mstrap = 1;
  logic [3:0] ltxd;
  plp_line_type line = '0;
  plp_mode_type mode;
  int mismatches = 0, total_checks = 0, cyc = 0, n, cnt;
  logic [15:0] d;
  always #25 clk_in = ~clk_in;
  // Pull-up on the management wire when nobody drives it
  assign mdio_w = mdio_oe ? mdio_o : drv;
  plp_ctrl #(.BREAK_CNT(BRK)) dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .mdc_in(mdc), .mdio_in(mdio_w), .mdio_out(mdio_o),
    .mdio_oe_out(mdio_oe), .auto_mdix_strap_in(1'b0),
    .manual_mdix_strap_in(mstrap), .line_energy_present_in(energy),
    .rx_rclk_in(line.rx_active), .ext_mii_sel_in(ext_sel), .line_in(line),
    .partner_word_in(16'h0000), .txd_in(txd), .txen_in(mtxen),
    .rx_nibble_in(rxn), .rx_valid_in(rxv), .rx_ready_out(rx_rdy),
    .mac_ready_in(mready), .rxd_out(rxd), .rxdv_out(rxdv),
    .rxclk_out(rxclk), .line_txd_out(ltxd), .line_txen_out(ltxen),
    .crs_out(crs), .col_out(col), .mode_out(mode),
    .an_start_out(an_st), .power_down_out(pd), .phy_irq_out(irq));
  plp_mac_model mac (.clk_in(clk_in), .send_in(send), .stall_in(stall),
    .rxd_in(rxd), .rxdv_in(rxdv), .txd_out(txd), .txen_out(mtxen),
    .mac_ready_out(mready), .got_out(got), .count_out(cnt));
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      mismatches++;
      conclude();
    end
  end
  task automatic tick(input int k);
    repeat (k) @(posedge clk_in);
    #1;
  endtask
  task automatic cmp(input string nm, input logic [15:0] e, g);
    total_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bitx(input logic b);
    drv = b;
    mdc = 1'b0;
    tick(4);
    mdc = 1'b1;
    tick(4);
  endtask
  task automatic frame(input logic rd, input logic [4:0] r,
    input logic [15:0] w);
    logic [13:0] h;
    logic [17:0] s;
    h = {2'h1, rd ? 2'h2 : 2'h1, 5'h01, r};
    s = rd ? 18'h3FFFF : {2'h2, w};
    repeat (32) bitx(1'b1);
    for (int i = 13; i >= 0; i--)
      bitx(h[i]);
    for (int i = 17; i >= 0; i--)
    begin
      bitx(s[i]);
      if (i >= 1 && i <= 16)
        d = {d[14:0], mdio_w};
    end
    drv = 1'b1;
  endtask
  initial
  begin
    tick(8);
    rst_n_in = 1'b1;
    tick(3);
    foreach (rows[i])
    begin
      frame(1'b1, rows[i].r, 16'h0000);
      cmp("reg read", rows[i].v, d);
    end
    line.signal_ok = 1'b1;
    line.an_done = 1'b1;
    line.pd_fault = 1'b1;
    tick(1);
    line.an_done = 1'b0;
    line.pd_fault = 1'b0;
    tick(2);
    frame(1'b1, REG_EXP, 16'h0000);
    cmp("expansion", 16'h0011, d);
    line.signal_ok = 1'b0;
    tick(2);
    line.signal_ok = 1'b1;
    line.mlt3_seen = 1'b1;
    tick(4);
    cmp("parallel mode", 16'h000D, {12'h000, mode});
    cmp("strap mdix", 16'h1, {15'h0, mode.mdix});
    frame(1'b1, REG_PARTNER, 16'h0000);
    cmp("partner", PA_SELECTOR | (16'h1 << PA_100_HALF), d);
    frame(1'b1, REG_EXP, 16'h0000);
    cmp("partner able", 16'h0, {15'h0, d[EXP_PARTNER_ABLE]});
    send = 1'b1;
    tick(3);
    cmp("crs half", 16'h1, {15'h0, crs});
    line.rx_active = 1'b1;
    tick(3);
    cmp("collision", 16'h1, {15'h0, col});
    cmp("rx clock", 16'h1, {15'h0, rxclk});
    stall = 1'b1;
    n = 0;
    while (rx_rdy && n < 12)
    begin
      rxn = n[3:0];
      rxv = 1'b1;
      tick(1);
      n++;
    end
    rxv = 1'b0;
    cmp("fifo refuse", 16'h1, {15'h0, n >= 8 && n <= 9});
    stall = 1'b0;
    tick(20);
    cmp("drained", n[15:0], cnt[15:0]);
    cmp("last nibble", {12'h0, 4'(n - 1)}, {12'h0, got});
    frame(1'b0, REG_SPECIAL, 16'h1 << SPC_OVERRIDE);
    tick(3);
    cmp("mdix", 16'h0, {15'h0, mode.mdix});
    frame(1'b0, REG_ADV, 16'h0061);
    cmp("adv no restart", 16'h1, {15'h0, mode.link_up});
    frame(1'b0, REG_CTRL, 16'h1 << CTRL_DUPLEX);
    tick(4);
    cmp("forced mode", 16'h000A, {12'h000, mode});
    cmp("no collision", 16'h0, {15'h0, col});
    line.rx_active = 1'b0;
    tick(3);
    cmp("crs full", 16'h0, {15'h0, crs});
    n = {31'h0, rxclk};
    tick(4);
    cmp("ref clock", {15'h0, ~n[0]}, {15'h0, rxclk});
    energy = 1'b1;
    tick(6);
    cmp("irq masked", 16'h0, {15'h0, irq});
    frame(1'b0, REG_INT_MASK, 16'h1 << INT_ENERGY);
    cmp("irq", 16'h1, {15'h0, irq});
    frame(1'b1, REG_INT_SRC, 16'h0000);
    cmp("source", 16'h00D4, d);
    tick(2);
    cmp("irq cleared", 16'h0, {15'h0, irq});
    ext_sel = 1'b1;
    tick(2);
    cmp("power down", 16'h1, {15'h0, pd});
    cmp("link off", 16'h0, {15'h0, mode.link_up});
    frame(1'b1, REG_INT_MASK, 16'h0000);
    cmp("mask kept", 16'h0080, d);
    ext_sel = 1'b0;
    tick(2);
    cmp("power up", 16'h0, {15'h0, pd});
    frame(1'b0, REG_CTRL, CTRL_RST | (16'h1 << CTRL_RESTART));
    cmp("traffic stopped", 16'h0, {15'h0, ltxen});
    n = 0;
    while (!an_st && n < 100)
    begin
      tick(1);
      n++;
    end
    cmp("break time", 16'h1, {15'h0, n > BRK - 12 && n <= BRK + 1});
    tick(6);
    line.signal_ok = 1'b0;
    n = 0;
    while (!an_st && n < 10)
    begin
      tick(1);
      n++;
    end
    cmp("loss restart", 16'h1, {15'h0, an_st});
    rst_n_in = 1'b0;
    tick(2);
    rst_n_in = 1'b1;
    tick(3);
    frame(1'b1, REG_INT_MASK, 16'h0000);
    cmp("mask reset", MASK_RST, d);
    conclude();
  end
endmodule
